// file: src/line_state_condition_pkg.sv
// Register map, field positions and constants for the line state condition block
package line_state_condition_pkg;

    // ---------------------------------------------------------------
    // Register offsets on the control bus
    // ---------------------------------------------------------------
    localparam logic [4:0] ADDR_RECEIVE_CONDITION_SECOND = 5'h0a;
    localparam logic [4:0] ADDR_RECEIVE_CONDITION_FIRST_MASK = 5'h0b;

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] RESET_RECEIVE_CONDITION_SECOND = 8'h00;
    localparam logic [7:0] RESET_RECEIVE_CONDITION_FIRST_MASK = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // ---------------------------------------------------------------
    // Second condition register fields
    // ---------------------------------------------------------------
    localparam int IDLE_LINE_STATE_FLAG_POS = 0;
    localparam int COUNT_EXPIRY_FLAG_POS = 1;
    localparam int ACTIVE_LINE_FLAG_POS = 2;
    localparam int UNKNOWN_LINE_VALID_FLAG_POS = 3;
    localparam int CASCADE_OR_SERVICE_EVENT_POS = 4;
    localparam int ELASTIC_BUFFER_FAULT_POS = 5;
    localparam int SUPER_IDLE_FLAG_POS = 6;
    localparam int SPARE_BIT_B7_POS = 7;

    // Bits that outside logic may set directly
    localparam logic [7:0] EXTERNAL_SET_BITS = 8'h3b;

    // ---------------------------------------------------------------
    // First condition mask fields
    // ---------------------------------------------------------------
    localparam int NO_SIGNAL_ENABLE_POS = 0;
    localparam int QUIET_LINE_ENABLE_POS = 1;
    localparam int HALT_LINE_ENABLE_POS = 2;
    localparam int MASTER_LINE_ENABLE_POS = 3;
    localparam int NOISE_LINE_ENABLE_POS = 4;
    localparam int NOISE_LIMIT_ENABLE_POS = 5;
    localparam int LINE_CHANGE_ENABLE_POS = 6;
    localparam int UNKNOWN_INVALID_ENABLE_POS = 7;

    // ---------------------------------------------------------------
    // Symbol pair patterns, first symbol in bits 9:5
    // ---------------------------------------------------------------
    localparam logic [9:0] PAIR_QUIET = 10'h000;
    localparam logic [9:0] PAIR_HALT = 10'h084;
    localparam logic [9:0] PAIR_MASTER = 10'h080;
    localparam logic [9:0] PAIR_IDLE = 10'h3ff;
    localparam logic [9:0] PAIR_START_JK = 10'h311;

    // Consecutive pairs needed to recognise a line state
    localparam int LINE_STATE_PAIRS = 8;

    // Pattern class of one symbol pair, one-hot
    typedef enum logic [4:0] {
        CLASS_OTHER  = 5'b00001,
        CLASS_QUIET  = 5'b00010,
        CLASS_HALT   = 5'b00100,
        CLASS_MASTER = 5'b01000,
        CLASS_IDLE   = 5'b10000
    } pair_class_t;

endpackage : line_state_condition_pkg

// file: src/line_state_condition_mask.sv
// Second receive condition register, first condition mask and summary bits
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// (RL1) Eight or more consecutive Idle pairs set the super idle flag.
// (RL2) The spare bit b7 resets to 0 and is freely written; it also feeds the second summary when its mask bit is 1.
// (RL3) Software may rewrite the first condition mask at any time.
// (RL4) The first summary is 1 whenever any first flag and its mask bit are both 1.
// (RL5) The first condition mask resets to all zero.
// (RL6) Mask bits 0 and 1 enable the no signal and quiet line flags.
// (RL7) Mask bits 2 and 3 enable the halt line and master line flags.
// (RL8) Mask bits 4 and 5 enable the noise line and noise limit flags.
// (RL9) Mask bits 6 and 7 enable the line change and unknown line invalid flags.
// (RL10) Entering a line state sets its flag and leaves other set flags as they were.
// (RL11) The second summary is 1 whenever any second flag and its mask bit are both 1.
// (RL12) Quiet, halt and master are recognised after eight consecutive matching pairs.
// (RL13) A JK starting delimiter pair sets the active line flag.
module line_state_condition_mask #(
    parameter int PAIRS_NEEDED = line_state_condition_pkg::LINE_STATE_PAIRS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control bus
    input wire logic [4:0] cbus_addr,
    input wire logic cbus_rd,
    input wire logic cbus_wr,
    input wire logic [7:0] cbus_wdata,
    output logic [7:0] cbus_rdata,
    // Received symbol pairs
    input wire logic pair_valid,
    input wire logic [9:0] pair_data,
    // Condition sources outside this block
    input wire logic [7:0] second_set,
    input wire logic [7:0] receive_condition_first,
    input wire logic [7:0] receive_condition_second_mask,
    // Summary bits and recognised line states
    output logic first_condition_summary,
    output logic second_condition_summary,
    output logic quiet_line_seen,
    output logic halt_line_seen,
    output logic master_line_seen
);

    // ---------------------------------------------------------------
    // Pair classification
    // ---------------------------------------------------------------
    function automatic line_state_condition_pkg::pair_class_t classify(input logic [9:0] pair);
        case (pair)
            line_state_condition_pkg::PAIR_QUIET: classify = line_state_condition_pkg::CLASS_QUIET;
            line_state_condition_pkg::PAIR_HALT: classify = line_state_condition_pkg::CLASS_HALT;
            line_state_condition_pkg::PAIR_MASTER: classify = line_state_condition_pkg::CLASS_MASTER;
            line_state_condition_pkg::PAIR_IDLE: classify = line_state_condition_pkg::CLASS_IDLE;
            default: classify = line_state_condition_pkg::CLASS_OTHER;
        endcase
    endfunction

    // ---------------------------------------------------------------
    // Run length recogniser
    // ---------------------------------------------------------------
    // Count saturates so a long run reports its line state only once
    line_state_condition_pkg::pair_class_t run_class;
    line_state_condition_pkg::pair_class_t next_run_class;
    logic [3:0] run_count;
    logic [3:0] next_run_count;
    logic run_hit;
    logic next_run_hit;
    line_state_condition_pkg::pair_class_t pair_class;
    logic [3:0] pairs_needed;

    assign pairs_needed = 4'(PAIRS_NEEDED);
    assign pair_class = classify(pair_data);

    always_comb begin
        next_run_class = run_class;
        next_run_count = run_count;
        next_run_hit = 1'b0;
        if (pair_valid) begin
            if (pair_class != run_class) begin
                next_run_class = pair_class;
                next_run_count = 4'h1;
            end else if (run_count < pairs_needed) begin
                next_run_count = run_count + 4'h1;
            end
            // Fires on the pair that completes the run
            next_run_hit = (next_run_count == pairs_needed) && (run_count != pairs_needed)
                && (pair_class != line_state_condition_pkg::CLASS_OTHER); // RL12 RL1
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_class <= line_state_condition_pkg::CLASS_OTHER;
            run_count <= 4'h0;
            run_hit <= 1'b0;
        end else begin
            run_class <= next_run_class;
            run_count <= next_run_count;
            run_hit <= next_run_hit;
        end
    end

    // Recognition is reported two cycles after the completing pair
    logic next_quiet_seen;
    logic next_halt_seen;
    logic next_master_seen;
    logic super_idle_hit;
    logic active_hit;

    always_comb begin
        next_quiet_seen = 1'b0;
        next_halt_seen = 1'b0;
        next_master_seen = 1'b0;
        super_idle_hit = 1'b0;
        if (run_hit) begin
            case (run_class)
                line_state_condition_pkg::CLASS_QUIET: next_quiet_seen = 1'b1; // RL12
                line_state_condition_pkg::CLASS_HALT: next_halt_seen = 1'b1; // RL12
                line_state_condition_pkg::CLASS_MASTER: next_master_seen = 1'b1; // RL12
                line_state_condition_pkg::CLASS_IDLE: super_idle_hit = 1'b1; // RL1
                default: super_idle_hit = 1'b0;
            endcase
        end
        active_hit = pair_valid && (pair_data == line_state_condition_pkg::PAIR_START_JK); // RL13
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_line_seen <= 1'b0;
            halt_line_seen <= 1'b0;
            master_line_seen <= 1'b0;
        end else begin
            quiet_line_seen <= next_quiet_seen;
            halt_line_seen <= next_halt_seen;
            master_line_seen <= next_master_seen;
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [7:0] receive_condition_second;
    logic [7:0] next_receive_condition_second;
    logic [7:0] receive_condition_first_mask;
    logic [7:0] next_receive_condition_first_mask;
    logic [7:0] next_cbus_rdata;
    logic [7:0] hw_set;
    logic wr_second;
    logic wr_mask;

    always_comb begin
        wr_second = cbus_wr && (cbus_addr == line_state_condition_pkg::ADDR_RECEIVE_CONDITION_SECOND);
        wr_mask = cbus_wr && (cbus_addr == line_state_condition_pkg::ADDR_RECEIVE_CONDITION_FIRST_MASK);
        hw_set = second_set & line_state_condition_pkg::EXTERNAL_SET_BITS;
        hw_set[line_state_condition_pkg::SUPER_IDLE_FLAG_POS] = super_idle_hit; // RL1
        hw_set[line_state_condition_pkg::ACTIVE_LINE_FLAG_POS] = active_hit; // RL13
        hw_set[line_state_condition_pkg::IDLE_LINE_STATE_FLAG_POS] =
            second_set[line_state_condition_pkg::IDLE_LINE_STATE_FLAG_POS];

        // Writing 0 clears a flag, 1 leaves it; a set in the same cycle wins
        next_receive_condition_second = receive_condition_second;
        if (wr_second) begin
            next_receive_condition_second = receive_condition_second & cbus_wdata;
            // Spare bit is plain storage, but it still feeds the second summary through its mask bit
            next_receive_condition_second[line_state_condition_pkg::SPARE_BIT_B7_POS] =
                cbus_wdata[line_state_condition_pkg::SPARE_BIT_B7_POS]; // RL2
        end
        next_receive_condition_second = next_receive_condition_second | hw_set; // RL10

        next_receive_condition_first_mask = receive_condition_first_mask;
        if (wr_mask) begin
            next_receive_condition_first_mask = cbus_wdata; // RL3
        end

        next_cbus_rdata = cbus_rdata;
        if (cbus_rd) begin
            case (cbus_addr)
                line_state_condition_pkg::ADDR_RECEIVE_CONDITION_SECOND:
                    next_cbus_rdata = receive_condition_second;
                line_state_condition_pkg::ADDR_RECEIVE_CONDITION_FIRST_MASK:
                    next_cbus_rdata = receive_condition_first_mask;
                default: next_cbus_rdata = line_state_condition_pkg::UNMAPPED_READ_VALUE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            receive_condition_second <= line_state_condition_pkg::RESET_RECEIVE_CONDITION_SECOND; // RL2
            receive_condition_first_mask <= line_state_condition_pkg::RESET_RECEIVE_CONDITION_FIRST_MASK; // RL5
            cbus_rdata <= line_state_condition_pkg::UNMAPPED_READ_VALUE;
        end else begin
            receive_condition_second <= next_receive_condition_second;
            receive_condition_first_mask <= next_receive_condition_first_mask;
            cbus_rdata <= next_cbus_rdata;
        end
    end

    // ---------------------------------------------------------------
    // Summary bits
    // ---------------------------------------------------------------
    // Bit n of the mask gates bit n of the first flags, one for one
    logic next_first_summary;
    logic next_second_summary;

    always_comb begin
        next_first_summary = |(receive_condition_first & receive_condition_first_mask); // RL4 RL6 RL7 RL8 RL9
        next_second_summary = |(receive_condition_second & receive_condition_second_mask); // RL11
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_condition_summary <= 1'b0;
            second_condition_summary <= 1'b0;
        end else begin
            first_condition_summary <= next_first_summary;
            second_condition_summary <= next_second_summary;
        end
    end

endmodule // line_state_condition_mask

`default_nettype wire

// file: dv/lsc_checker_properties.sv
// Port-level assertions for the line state condition block
`timescale 1ns/1ps
`default_nettype none
module lsc_checker #(
    parameter int PAIRS_NEEDED = line_state_condition_pkg::LINE_STATE_PAIRS
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [4:0] cbus_addr,
    input wire logic cbus_rd,
    input wire logic cbus_wr,
    input wire logic [7:0] cbus_wdata,
    input wire logic [7:0] cbus_rdata,
    input wire logic pair_valid,
    input wire logic [9:0] pair_data,
    input wire logic [7:0] receive_condition_first,
    input wire logic [7:0] receive_condition_second_mask,
    input wire logic first_condition_summary,
    input wire logic second_condition_summary,
    input wire logic quiet_line_seen,
    input wire logic halt_line_seen,
    input wire logic master_line_seen
);
    localparam logic [4:0] A_MSK = line_state_condition_pkg::ADDR_RECEIVE_CONDITION_FIRST_MASK;
    localparam logic [4:0] A_SEC = line_state_condition_pkg::ADDR_RECEIVE_CONDITION_SECOND;
    logic [7:0] mask_copy;
    logic [7:0] next_mask_copy;
    logic any_seen;
    // Shadow of the mask, since the checker sees only ports
    always_comb begin
        next_mask_copy = (cbus_wr && cbus_addr == A_MSK) ? cbus_wdata : mask_copy;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_copy <= 8'h00;
        end else begin
            mask_copy <= next_mask_copy;
        end
    end
    assign any_seen = quiet_line_seen || halt_line_seen || master_line_seen;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    first_summary_match_a: assert property (
        first_condition_summary == |($past(receive_condition_first) & $past(mask_copy)))
        else $error("first summary disagrees with flags and mask");
    mask_read_back_a: assert property (cbus_rd && cbus_addr == A_MSK |=>
        cbus_rdata == $past(mask_copy)) else $error("mask read data wrong");
    unmapped_read_zero_a: assert property (cbus_rd && cbus_addr != A_MSK && cbus_addr != A_SEC
        |=> cbus_rdata == 8'h00) else $error("unmapped read not zero");
    second_summary_masked_a: assert property (
        $past(receive_condition_second_mask) == 8'h00 |-> !second_condition_summary)
        else $error("second summary high with empty mask");
    seen_single_pulse_a: assert property (any_seen |=> !any_seen)
        else $error("line state pulse longer than one cycle");
    seen_one_hot_a: assert property ($onehot0({quiet_line_seen, halt_line_seen,
        master_line_seen})) else $error("two line states at once");
    // Pulse stands two edges after the completing pair is taken
    quiet_cause_a: assert property (quiet_line_seen |-> $past(pair_valid, 2) &&
        $past(pair_data, 2) == line_state_condition_pkg::PAIR_QUIET) else $error("quiet cause");
    halt_cause_a: assert property (halt_line_seen |-> $past(pair_valid, 2) &&
        $past(pair_data, 2) == line_state_condition_pkg::PAIR_HALT) else $error("halt cause");
    master_cause_a: assert property (master_line_seen |-> $past(pair_valid, 2) &&
        $past(pair_data, 2) == line_state_condition_pkg::PAIR_MASTER) else $error("master cause");
    cover property (quiet_line_seen);
    cover property (master_line_seen);
    cover property (first_condition_summary && second_condition_summary);
endmodule // lsc_checker
bind line_state_condition_mask lsc_checker #(.PAIRS_NEEDED(PAIRS_NEEDED)) i_chk (
    .core_clk(core_clk), .rst_n(rst_n), .cbus_addr(cbus_addr), .cbus_rd(cbus_rd),
    .cbus_wr(cbus_wr), .cbus_wdata(cbus_wdata), .cbus_rdata(cbus_rdata),
    .pair_valid(pair_valid), .pair_data(pair_data),
    .receive_condition_first(receive_condition_first),
    .receive_condition_second_mask(receive_condition_second_mask),
    .first_condition_summary(first_condition_summary),
    .second_condition_summary(second_condition_summary), .quiet_line_seen(quiet_line_seen),
    .halt_line_seen(halt_line_seen), .master_line_seen(master_line_seen));
`default_nettype wire

// file: dv/mgmt_cpu.sv
// Management processor model driving the control bus
`timescale 1ns/1ps
`default_nettype none
module mgmt_cpu (
    // Clock
    input wire logic core_clk,
    // Control bus
    output logic [4:0] cbus_addr,
    output logic cbus_rd,
    output logic cbus_wr,
    output logic [7:0] cbus_wdata,
    input wire logic [7:0] cbus_rdata
);
    initial begin
        cbus_addr = 5'h00;
        cbus_rd = 1'b0;
        cbus_wr = 1'b0;
        cbus_wdata = 8'h00;
    end
    // Data is inverted after the strobe so a stale value is never mistaken for a live one
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(negedge core_clk);
        cbus_addr = a;
        cbus_wdata = d;
        cbus_wr = 1'b1;
        @(negedge core_clk);
        cbus_wr = 1'b0;
        cbus_wdata = ~d;
    endtask
    task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
        @(negedge core_clk);
        cbus_addr = a;
        cbus_rd = 1'b1;
        @(negedge core_clk);
        cbus_rd = 1'b0;
        @(negedge core_clk);
        d = cbus_rdata;
    endtask
endmodule // mgmt_cpu
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the line state condition block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [4:0] A_SEC = line_state_condition_pkg::ADDR_RECEIVE_CONDITION_SECOND;
    localparam logic [4:0] A_MSK = line_state_condition_pkg::ADDR_RECEIVE_CONDITION_FIRST_MASK;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] cbus_addr;
    logic cbus_rd, cbus_wr, sum1, sum2, q_seen, h_seen, m_seen;
    logic pair_valid = 1'b0;
    logic [7:0] cbus_wdata, cbus_rdata, rd_val;
    logic [9:0] pair_data = 10'h000;
    logic [7:0] second_set = 8'h00, first = 8'h00, second_mask = 8'h00;
    int miscompares = 0, n_checks = 0, seen_cnt = 0;
    logic [9:0] pats [3] = '{line_state_condition_pkg::PAIR_QUIET,
        line_state_condition_pkg::PAIR_HALT, line_state_condition_pkg::PAIR_MASTER};
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) seen_cnt <= seen_cnt + q_seen + h_seen + m_seen;
    mgmt_cpu i_cpu (.core_clk(core_clk), .cbus_addr(cbus_addr), .cbus_rd(cbus_rd),
        .cbus_wr(cbus_wr), .cbus_wdata(cbus_wdata), .cbus_rdata(cbus_rdata));
    line_state_condition_mask #(.PAIRS_NEEDED(8)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .cbus_addr(cbus_addr), .cbus_rd(cbus_rd), .cbus_wr(cbus_wr), .cbus_wdata(cbus_wdata),
        .cbus_rdata(cbus_rdata), .pair_valid(pair_valid), .pair_data(pair_data),
        .second_set(second_set), .receive_condition_first(first),
        .receive_condition_second_mask(second_mask), .first_condition_summary(sum1),
        .second_condition_summary(sum2), .quiet_line_seen(q_seen),
        .halt_line_seen(h_seen), .master_line_seen(m_seen));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
        i_cpu.rd_reg(a, rd_val);
        chk(what, rd_val, exp);
    endtask
    task automatic send(input logic [9:0] p, input int n);
        repeat (n) begin
            @(negedge core_clk);
            pair_valid = 1'b1;
            pair_data = p;
            @(negedge core_clk);
            pair_valid = 1'b0;
            pair_data = ~p;
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #500000;
        miscompares++;
        tally_and_finish();
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        rd(A_SEC, 8'h00, "second after reset");
        rd(A_MSK, 8'h00, "mask after reset");
        first = 8'hff;
        i_cpu.wr_reg(5'h1f, 8'hff);
        rd(5'h1f, 8'h00, "unmapped read");
        chk("summary while masked", sum1, 8'h00);
        rd(A_MSK, 8'h00, "mask after unmapped write");
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            i_cpu.wr_reg(A_MSK, 8'h01 << i);
            first = 8'h01 << i;
            repeat (2) @(negedge core_clk);
            chk("first summary set", sum1, 8'h01);
            first = ~(8'h01 << i);
            repeat (2) @(negedge core_clk);
            chk("first summary masked", sum1, 8'h00);
            rd(A_MSK, 8'h01 << i, "mask readback");
        end
        $display("test mask bits done");
        // A different pair inside the run must restart the count
        for (int k = 0; k < 3; k++) begin
            send(pats[k], 7);
            send(line_state_condition_pkg::PAIR_START_JK, 1);
            send(pats[k], 8);
            // The pulse stands for one cycle only, so look one cycle after the run
            @(negedge core_clk);
            chk("line seen", {5'h00, q_seen, h_seen, m_seen}, 8'h04 >> k);
            send(pats[k], 3);
            chk("pulse count", 8'(seen_cnt), 8'(k + 1));
        end
        $display("test line states done");
        rd(A_SEC, 8'h04, "active line");
        send(line_state_condition_pkg::PAIR_IDLE, 8);
        repeat (2) @(negedge core_clk);
        rd(A_SEC, 8'h44, "super idle");
        @(negedge core_clk);
        second_set = 8'hff;
        @(negedge core_clk);
        second_set = 8'h00;
        rd(A_SEC, 8'h7f, "sticky flags");
        second_mask = 8'h40;
        repeat (2) @(negedge core_clk);
        chk("second summary", sum2, 8'h01);
        i_cpu.wr_reg(A_SEC, 8'h80);
        rd(A_SEC, 8'h80, "spare bit");
        chk("second summary cleared", sum2, 8'h00);
        rd(A_MSK, 8'h80, "mask kept");
        second_set = 8'h01;
        i_cpu.wr_reg(A_SEC, 8'h00);
        second_set = 8'h00;
        rd(A_SEC, 8'h01, "set beats clear");
        $display("test second register done");
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
